// File: rtl/vcf_enc_decode.sv
// Splits a field encoding operand into its parts and flags illegal encodings.
// Assumes the operand is held stable by the caller; purely combinational.
`timescale 1ns/100ps
module vcf_enc_decode (
  input wire logic [63:0] operand,
  input wire logic mode64,
  output vcf_pkg::vcf_enc_t dec,
  output logic enc_bad
);

  logic above_range;
  logic rsv_set;
  logic high_bad;

  always_comb begin
    dec.high = operand[vcf_pkg::ENC_ACC]; // see (R2)
    dec.index = operand[vcf_pkg::ENC_IDX_MSB:vcf_pkg::ENC_IDX_LSB]; // see (R3)
    dec.ftype = vcf_pkg::vcf_ftype_t'(
      operand[vcf_pkg::ENC_TYPE_MSB:vcf_pkg::ENC_TYPE_LSB]); // see (R4)
    dec.width = vcf_pkg::vcf_width_t'(
      operand[vcf_pkg::ENC_WID_MSB:vcf_pkg::ENC_WID_LSB]); // see (R6)
    // Upper operand half only counts in 64-bit mode
    above_range = mode64 && (operand[63:vcf_pkg::ENC_MSB+1] != 32'h0); // see (R1)
    rsv_set = operand[vcf_pkg::ENC_RSV_LO]
      || (operand[vcf_pkg::ENC_MSB:vcf_pkg::ENC_RSV_HI_LSB] != 17'h0); // see (R22)
    high_bad = dec.high && (dec.width != vcf_pkg::VCF_W64); // see (R2) (R22)
    enc_bad = above_range || rsv_set || high_bad;
  end

endmodule // vcf_enc_decode

// File: rtl/vcf_field_access.sv
// Control-structure field store with encoded field reads and writes, launch
// state, entry checks and enable-region checks, reached over APB.
// Assumes APB master on pclk; a command runs one cycle after its CMD write.
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Operation
// (R1) 64-bit mode: encoding bits above 31 fail
// (R2) Bit 0 access type; high only for 64-bit
// (R3) Bits 9:1 index separate same-kind fields
// (R4) Bits 11:10 give field category
// (R5) Issuer keeps bits 12, 31:15 zero
// (R6) Bits 14:13 give field width
// (R7) Natural width 64 or 32 by core
// (R8) High access touches upper 32 bits only
// (R9) 16-bit: low 16 bits, rest zero
// (R10) 32-bit: low 32 bits, upper cleared
// (R11) Outside 64-bit mode: low half, upper cleared
// (R12) 64-bit mode full access moves 64 bits
// (R13) High read/write maps field upper to low
// (R14) Issuer writes full half before high half
// (R15) Launch state not reachable by field write
// (R16) Clear resets launch state; entry op order
// (R17) Entry activates link shadow; clear before migration
// (R18) Pointer 4K aligned, within address width
// (R19) Region word holds revision, bit 31 clear
// (R20) Pointed structures outside field access reach
// (R21) Region bit 31 marks shadow structure
// (R22) Reserved bits or bad high type fail
module vcf_field_access #(
  parameter int IDX_BITS = 2,
  parameter int PA_WIDTH = 40,
  parameter bit CPU64 = 1'b1,
  // Arbitrary revision identifier value
  parameter logic [30:0] REVISION_ID = 31'h0000_0001
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  localparam int MEM_BITS = 4 + IDX_BITS;
  localparam int MEM_DEPTH = 1 << MEM_BITS;

  generate
    if (IDX_BITS < 1 || IDX_BITS > 9 || PA_WIDTH < 13 || PA_WIDTH > 64) begin : g_chk
      $error("vcf_field_access: unsupported IDX_BITS or PA_WIDTH");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic mode64_reg;
  logic [63:0] enc_reg;
  logic [63:0] src_reg;
  logic [63:0] res_reg;
  logic [63:0] ptr_reg;
  logic [31:0] hdr_reg;
  logic [63:0] link_reg;
  vcf_pkg::vcf_op_t op_reg;
  logic exec_reg;
  logic fail_reg;
  vcf_pkg::vcf_err_t err_reg;
  logic enabled_reg;
  logic cur_valid_reg;
  logic [63:0] cur_ptr_reg;
  logic cur_shadow_reg;
  logic launched_reg;
  logic shadow_act_reg;
  logic [63:0] field_mem [MEM_DEPTH];

  logic access;
  logic wr_fire;
  logic mapped;
  logic [31:0] rd_mux;
  vcf_pkg::vcf_enc_t dec;
  logic enc_bad;
  logic idx_out;
  logic [MEM_BITS-1:0] mem_addr;
  logic [63:0] field_old;
  logic [63:0] rd_data;
  logic [63:0] wr_data;
  vcf_pkg::vcf_err_t err_next;
  logic field_we;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic ptr_ok(input logic [63:0] p);
    logic [63:0] hi_mask;
    hi_mask = ~((64'h1 << PA_WIDTH) - 64'h1);
    ptr_ok = (p[vcf_pkg::PAGE_BITS-1:0] == 12'h0) && ((p & hi_mask) == 64'h0); // see (R18)
  endfunction

  function automatic logic wr_hit(input logic [7:0] off);
    wr_hit = wr_fire && (paddr == off);
  endfunction

  // ----------------------------------------------------------------
  // APB slave: one wait state, answer registered
  // ----------------------------------------------------------------
  assign access = psel && penable;
  assign wr_fire = access && pwrite && pready_reg;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0;
    unique case (paddr)
      vcf_pkg::OFF_CTRL: rd_mux = {31'h0, mode64_reg};
      vcf_pkg::OFF_CMD: rd_mux = {28'h0, op_reg};
      vcf_pkg::OFF_ENC_LO: rd_mux = enc_reg[31:0];
      vcf_pkg::OFF_ENC_HI: rd_mux = enc_reg[63:32];
      vcf_pkg::OFF_SRC_LO: rd_mux = src_reg[31:0];
      vcf_pkg::OFF_SRC_HI: rd_mux = src_reg[63:32];
      vcf_pkg::OFF_RES_LO: rd_mux = res_reg[31:0];
      vcf_pkg::OFF_RES_HI: rd_mux = res_reg[63:32];
      vcf_pkg::OFF_STATUS: begin
        rd_mux[vcf_pkg::ST_FAIL] = fail_reg;
        rd_mux[vcf_pkg::ST_BUSY] = exec_reg;
        rd_mux[vcf_pkg::ST_CUR_VALID] = cur_valid_reg;
        rd_mux[vcf_pkg::ST_LAUNCHED] = launched_reg;
        rd_mux[vcf_pkg::ST_ENABLED] = enabled_reg;
        rd_mux[vcf_pkg::ST_SHADOW_ACT] = shadow_act_reg;
        rd_mux[vcf_pkg::ST_CUR_SHADOW] = cur_shadow_reg;
        rd_mux[vcf_pkg::ST_ERR_MSB:vcf_pkg::ST_ERR_LSB] = err_reg;
      end
      vcf_pkg::OFF_PTR_LO: rd_mux = ptr_reg[31:0];
      vcf_pkg::OFF_PTR_HI: rd_mux = ptr_reg[63:32];
      vcf_pkg::OFF_HDR: rd_mux = hdr_reg;
      vcf_pkg::OFF_LINK_LO: rd_mux = link_reg[31:0];
      vcf_pkg::OFF_LINK_HI: rd_mux = link_reg[63:32];
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= access && !pready_reg;
      if (access && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0 : rd_mux;
        pslverr_reg <= !mapped;
      end else begin
        prdata_reg <= 32'h0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Software-written registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode64_reg <= 1'b0;
      enc_reg <= 64'h0;
      src_reg <= 64'h0;
      ptr_reg <= 64'h0;
      hdr_reg <= 32'h0;
      link_reg <= '1;
    end else begin
      // 64-bit mode exists only on a 64-bit capable core
      if (wr_hit(vcf_pkg::OFF_CTRL)) mode64_reg <= CPU64 && pwdata[vcf_pkg::CTRL_MODE64];
      if (wr_hit(vcf_pkg::OFF_ENC_LO)) enc_reg[31:0] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_ENC_HI)) enc_reg[63:32] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_SRC_LO)) src_reg[31:0] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_SRC_HI)) src_reg[63:32] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_PTR_LO)) ptr_reg[31:0] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_PTR_HI)) ptr_reg[63:32] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_HDR)) hdr_reg <= pwdata;
      if (wr_hit(vcf_pkg::OFF_LINK_LO)) link_reg[31:0] <= pwdata;
      if (wr_hit(vcf_pkg::OFF_LINK_HI)) link_reg[63:32] <= pwdata;
    end
  end

  // Command latch; the command runs in the following cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_reg <= vcf_pkg::OP_NONE;
      exec_reg <= 1'b0;
    end else begin
      exec_reg <= wr_hit(vcf_pkg::OFF_CMD);
      if (wr_hit(vcf_pkg::OFF_CMD)) op_reg <= vcf_pkg::vcf_op_t'(pwdata[3:0]);
    end
  end

  // ----------------------------------------------------------------
  // Encoding decode and data shaping
  // ----------------------------------------------------------------
  vcf_enc_decode u_dec (
    .operand(enc_reg),
    .mode64(mode64_reg),
    .dec(dec),
    .enc_bad(enc_bad)
  );

  // Only the low index bits are stored; higher indices have no field
  assign idx_out = (dec.index >> IDX_BITS) != 9'h0;
  assign mem_addr = {dec.width, dec.ftype, dec.index[IDX_BITS-1:0]}; // see (R3)
  assign field_old = field_mem[mem_addr];

  vcf_field_xfer #(
    .CPU64(CPU64)
  ) u_xfer (
    .width(dec.width),
    .high(dec.high),
    .mode64(mode64_reg),
    .field_old(field_old),
    .src(src_reg),
    .rd_data(rd_data),
    .wr_data(wr_data)
  );

  // ----------------------------------------------------------------
  // Command checks
  // ----------------------------------------------------------------
  always_comb begin
    err_next = vcf_pkg::ERR_NONE;
    unique case (op_reg)
      vcf_pkg::OP_FIELD_READ, vcf_pkg::OP_FIELD_WRITE: begin
        if (!enabled_reg) err_next = vcf_pkg::ERR_NOT_ENABLED;
        else if (!cur_valid_reg) err_next = vcf_pkg::ERR_NO_CURRENT;
        else if (enc_bad) err_next = vcf_pkg::ERR_BAD_ENC; // see (R1) (R22)
        else if (idx_out) err_next = vcf_pkg::ERR_NO_FIELD;
      end
      vcf_pkg::OP_CLEAR, vcf_pkg::OP_LOAD: begin
        if (!enabled_reg) err_next = vcf_pkg::ERR_NOT_ENABLED;
        else if (!ptr_ok(ptr_reg)) err_next = vcf_pkg::ERR_BAD_PTR; // see (R18)
      end
      vcf_pkg::OP_FIRST_ENTRY, vcf_pkg::OP_REPEAT_ENTRY: begin
        if (!enabled_reg) err_next = vcf_pkg::ERR_NOT_ENABLED;
        else if (!cur_valid_reg) err_next = vcf_pkg::ERR_NO_CURRENT;
        else if (cur_shadow_reg) err_next = vcf_pkg::ERR_SHADOW_ENTRY; // see (R21)
        else if (launched_reg == (op_reg == vcf_pkg::OP_FIRST_ENTRY))
          err_next = vcf_pkg::ERR_LAUNCH_STATE; // see (R16)
      end
      vcf_pkg::OP_VIRT_ENABLE: begin
        if (!ptr_ok(ptr_reg)) err_next = vcf_pkg::ERR_BAD_PTR; // see (R18)
        else if (hdr_reg != {1'b0, REVISION_ID}) err_next = vcf_pkg::ERR_BAD_REV; // see (R19)
      end
      vcf_pkg::OP_VIRT_DISABLE: err_next = vcf_pkg::ERR_NONE;
      default: err_next = vcf_pkg::ERR_BAD_OP;
    endcase
  end

  assign field_we = exec_reg && op_reg == vcf_pkg::OP_FIELD_WRITE
    && err_next == vcf_pkg::ERR_NONE;

  // ----------------------------------------------------------------
  // Field store; launch state is kept apart from it
  // ----------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (field_we) field_mem[mem_addr] <= wr_data; // see (R15)
  end

  // Read result and outcome of each command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_reg <= 64'h0;
      fail_reg <= 1'b0;
      err_reg <= vcf_pkg::ERR_NONE;
    end else if (exec_reg) begin
      fail_reg <= err_next != vcf_pkg::ERR_NONE;
      err_reg <= err_next;
      if (op_reg == vcf_pkg::OP_FIELD_READ && err_next == vcf_pkg::ERR_NONE)
        res_reg <= rd_data; // see (R9) (R10) (R11) (R12) (R13)
    end
  end

  // ----------------------------------------------------------------
  // Enable state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled_reg <= 1'b0;
    end else if (exec_reg && err_next == vcf_pkg::ERR_NONE) begin
      if (op_reg == vcf_pkg::OP_VIRT_ENABLE) enabled_reg <= 1'b1;
      else if (op_reg == vcf_pkg::OP_VIRT_DISABLE) enabled_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Current structure and launch state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_valid_reg <= 1'b0;
      cur_ptr_reg <= 64'h0;
      cur_shadow_reg <= 1'b0;
      launched_reg <= 1'b0;
    end else if (exec_reg && err_next == vcf_pkg::ERR_NONE) begin
      unique case (op_reg)
        vcf_pkg::OP_LOAD: begin
          cur_valid_reg <= 1'b1;
          cur_ptr_reg <= ptr_reg;
          cur_shadow_reg <= hdr_reg[vcf_pkg::HDR_SHADOW]; // see (R21)
          // A different structure starts untracked, so as cleared
          if (!cur_valid_reg || ptr_reg != cur_ptr_reg) launched_reg <= 1'b0;
        end
        vcf_pkg::OP_CLEAR: begin
          if (ptr_reg == cur_ptr_reg) begin
            launched_reg <= 1'b0; // see (R16)
            cur_valid_reg <= 1'b0;
          end
        end
        vcf_pkg::OP_FIRST_ENTRY: launched_reg <= 1'b1; // see (R16)
        vcf_pkg::OP_VIRT_DISABLE: cur_valid_reg <= 1'b0;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shadow structure made active by entry
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_act_reg <= 1'b0;
    end else if (exec_reg && err_next == vcf_pkg::ERR_NONE) begin
      if ((op_reg == vcf_pkg::OP_FIRST_ENTRY || op_reg == vcf_pkg::OP_REPEAT_ENTRY)
          && link_reg != '1)
        shadow_act_reg <= 1'b1; // see (R17)
      else if (op_reg == vcf_pkg::OP_CLEAR && ptr_reg == link_reg)
        shadow_act_reg <= 1'b0; // see (R17)
      else if (op_reg == vcf_pkg::OP_VIRT_DISABLE)
        shadow_act_reg <= 1'b0;
    end
  end

endmodule // vcf_field_access

// File: rtl/vcf_field_xfer.sv
// Width and mode dependent shaping of field read data and field write data.
// Assumes the decoded encoding is legal; combinational only.
`timescale 1ns/100ps
module vcf_field_xfer #(
  parameter bit CPU64 = 1'b1
) (
  input wire vcf_pkg::vcf_width_t width,
  input wire logic high,
  input wire logic mode64,
  input wire logic [63:0] field_old,
  input wire logic [63:0] src,
  output logic [63:0] rd_data,
  output logic [63:0] wr_data
);

  logic wide;

  always_comb begin
    wide = (width == vcf_pkg::VCF_W64) || (width == vcf_pkg::VCF_WNAT);
    rd_data = 64'h0;
    wr_data = field_old;
    if (high) begin
      rd_data = {32'h0, field_old[63:32]}; // see (R8) (R13)
      wr_data = {src[31:0], field_old[31:0]}; // see (R13)
    end else if (width == vcf_pkg::VCF_W16) begin
      rd_data = {48'h0, field_old[15:0]}; // see (R9)
      wr_data = {48'h0, src[15:0]}; // see (R9)
    end else if (width == vcf_pkg::VCF_W32) begin
      rd_data = {32'h0, field_old[31:0]}; // see (R10)
      wr_data = {32'h0, src[31:0]}; // see (R10)
    end else if (wide && mode64) begin
      rd_data = field_old; // see (R12)
      wr_data = src; // see (R12)
    end else begin
      rd_data = {32'h0, field_old[31:0]}; // see (R11)
      wr_data = {32'h0, src[31:0]}; // see (R11)
    end
    // Natural width is only 32 bits on a core without 64-bit support
    if (!CPU64 && width == vcf_pkg::VCF_WNAT) begin
      rd_data[63:32] = 32'h0; // see (R7)
      wr_data[63:32] = 32'h0; // see (R7)
    end
  end

endmodule // vcf_field_xfer

// File: rtl/vcf_pkg.sv
// Constants, field layouts and types for the field access block.
// Assumes an APB slave with 32-bit data and byte addresses on an 8-bit offset.
package vcf_pkg;

  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_ENC_LO = 8'h08;
  localparam logic [7:0] OFF_ENC_HI = 8'h0c;
  localparam logic [7:0] OFF_SRC_LO = 8'h10;
  localparam logic [7:0] OFF_SRC_HI = 8'h14;
  localparam logic [7:0] OFF_RES_LO = 8'h18;
  localparam logic [7:0] OFF_RES_HI = 8'h1c;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_PTR_LO = 8'h24;
  localparam logic [7:0] OFF_PTR_HI = 8'h28;
  localparam logic [7:0] OFF_HDR = 8'h2c;
  localparam logic [7:0] OFF_LINK_LO = 8'h30;
  localparam logic [7:0] OFF_LINK_HI = 8'h34;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE64 = 0;
  localparam int ENC_ACC = 0;
  localparam int ENC_IDX_LSB = 1;
  localparam int ENC_IDX_MSB = 9;
  localparam int ENC_TYPE_LSB = 10;
  localparam int ENC_TYPE_MSB = 11;
  localparam int ENC_RSV_LO = 12;
  localparam int ENC_WID_LSB = 13;
  localparam int ENC_WID_MSB = 14;
  localparam int ENC_RSV_HI_LSB = 15;
  localparam int ENC_MSB = 31;
  localparam int HDR_SHADOW = 31;
  localparam int HDR_REV_MSB = 30;
  localparam int PAGE_BITS = 12;
  localparam int ST_FAIL = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_CUR_VALID = 2;
  localparam int ST_LAUNCHED = 3;
  localparam int ST_ENABLED = 4;
  localparam int ST_SHADOW_ACT = 5;
  localparam int ST_CUR_SHADOW = 6;
  localparam int ST_ERR_LSB = 8;
  localparam int ST_ERR_MSB = 11;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VCF_W16 = 2'b00,
    VCF_W64 = 2'b01,
    VCF_W32 = 2'b10,
    VCF_WNAT = 2'b11
  } vcf_width_t;

  typedef enum logic [1:0] {
    VCF_T_CTRL = 2'b00,
    VCF_T_EXIT = 2'b01,
    VCF_T_GUEST = 2'b10,
    VCF_T_HOST = 2'b11
  } vcf_ftype_t;

  typedef struct packed {
    logic high;
    logic [8:0] index;
    vcf_ftype_t ftype;
    vcf_width_t width;
  } vcf_enc_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_FIELD_READ = 4'h1,
    OP_FIELD_WRITE = 4'h2,
    OP_CLEAR = 4'h3,
    OP_LOAD = 4'h4,
    OP_FIRST_ENTRY = 4'h5,
    OP_REPEAT_ENTRY = 4'h6,
    OP_VIRT_ENABLE = 4'h7,
    OP_VIRT_DISABLE = 4'h8
  } vcf_op_t;

  typedef enum logic [3:0] {
    ERR_NONE = 4'h0,
    ERR_BAD_ENC = 4'h1,
    ERR_NO_CURRENT = 4'h2,
    ERR_BAD_PTR = 4'h3,
    ERR_BAD_REV = 4'h4,
    ERR_NOT_ENABLED = 4'h5,
    ERR_LAUNCH_STATE = 4'h6,
    ERR_SHADOW_ENTRY = 4'h7,
    ERR_BAD_OP = 4'h8,
    ERR_NO_FIELD = 4'h9
  } vcf_err_t;

endpackage

// File: verification/vcf_field_access_asserts.sv
// Bus-level checker for the field access block.
// Assumes it is bound to the top module and sees only its APB ports.
`timescale 1ns/100ps
module vcf_field_access_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic mapped;

  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= vcf_pkg::OFF_LINK_HI);
  a_ready_after_wait: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready without access wait");
  a_access_answer: assert property (psel && $rose(penable) |=> pready && psel && penable)
    else $error("access answered late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("ready outside an access");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("error on a mapped access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_rdata_quiet: assert property (!(pready && !pwrite && !pslverr) |-> prdata == 32'h0)
    else $error("read data not zero");
  a_busy_hidden: assert property (pready && !pwrite && paddr == vcf_pkg::OFF_STATUS
      |-> !prdata[vcf_pkg::ST_BUSY])
    else $error("busy seen by a status read");

  c_write: cover property (pready && pwrite);
  c_read: cover property (pready && !pwrite && !pslverr);
  c_error: cover property (pready && pslverr);
  c_fail: cover property (pready && !pwrite && paddr == vcf_pkg::OFF_STATUS && prdata[0]);
endmodule // vcf_field_access_asserts

bind vcf_field_access vcf_field_access_asserts u_asserts (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);

// File: verification/vcf_field_access_tb.sv
// Self-checking bench for the field access block over APB.
// Assumes default design parameters except the revision value below.
`timescale 1ns/100ps
module vcf_field_access_tb;
  // Arbitrary revision identifier value
  localparam logic [30:0] REV = 31'h0000_0005;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdq;
  logic rde;
  logic [63:0] res;
  logic [63:0] v;
  logic [31:0] bad [6] = '{32'h0000_1000, 32'h0000_8000, 32'h8000_0000, 32'h0000_0003,
                           32'h0000_4003, 32'h0000_6003};
  int error_cnt = 0;
  int tests_run = 0;

  always #10 pclk = ~pclk;

  vcf_field_access #(.REVISION_ID(REV)) uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic op(input logic [3:0] code, input logic [3:0] e);
    wr(vcf_pkg::OFF_CMD, {28'h0, code});
    rd(vcf_pkg::OFF_STATUS);
    check("status err", {59'h0, rdq[11:8], rdq[0]}, {59'h0, e, e != 4'h0});
  endtask

  task automatic flag(input int b, input logic x);
    rd(vcf_pkg::OFF_STATUS);
    check("status flag", {63'h0, rdq[b]}, {63'h0, x});
  endtask

  task automatic fwr(input logic [31:0] en, input logic [63:0] d, input logic [3:0] e);
    wr(vcf_pkg::OFF_ENC_LO, en);
    wr(vcf_pkg::OFF_SRC_LO, d[31:0]);
    wr(vcf_pkg::OFF_SRC_HI, d[63:32]);
    op(vcf_pkg::OP_FIELD_WRITE, e);
  endtask

  task automatic frd(input logic [31:0] en, input logic [3:0] e);
    wr(vcf_pkg::OFF_ENC_LO, en);
    op(vcf_pkg::OP_FIELD_READ, e);
    rd(vcf_pkg::OFF_RES_LO);
    res[31:0] = rdq;
    rd(vcf_pkg::OFF_RES_HI);
    res[63:32] = rdq;
  endtask

  function automatic logic [31:0] enc(input logic [1:0] wd, input logic [1:0] ty,
      input logic [8:0] ix, input logic hi);
    return {17'h0, wd, 1'b0, ty, ix, hi};
  endfunction

  function automatic logic [63:0] shape(input logic [1:0] wd, input logic [63:0] d);
    case (wd)
      2'b00: return {48'h0, d[15:0]};
      2'b10: return {32'h0, d[31:0]};
      default: return d;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    #200_000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(vcf_pkg::OFF_LINK_HI);
    check("link reset", {32'h0, rdq}, 64'hffff_ffff);
    rd(vcf_pkg::OFF_STATUS);
    check("status reset", {32'h0, rdq}, 64'h0);
    rd(8'h38);
    check("unmapped", {31'h0, rde, rdq}, {31'h0, 1'b1, 32'h0});
    op(vcf_pkg::OP_FIELD_READ, vcf_pkg::ERR_NOT_ENABLED);
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_1004);
    op(vcf_pkg::OP_VIRT_ENABLE, vcf_pkg::ERR_BAD_PTR);
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_1000);
    wr(vcf_pkg::OFF_PTR_HI, 32'h0000_0100);
    op(vcf_pkg::OP_VIRT_ENABLE, vcf_pkg::ERR_BAD_PTR);
    wr(vcf_pkg::OFF_PTR_HI, 32'h0000_0080);
    wr(vcf_pkg::OFF_HDR, {1'b1, REV});
    op(vcf_pkg::OP_VIRT_ENABLE, vcf_pkg::ERR_BAD_REV);
    wr(vcf_pkg::OFF_HDR, {1'b0, REV});
    op(vcf_pkg::OP_VIRT_ENABLE, 4'h0);
    wr(vcf_pkg::OFF_PTR_HI, 32'h0);
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_2000);
    op(vcf_pkg::OP_LOAD, 4'h0);
    wr(vcf_pkg::OFF_CTRL, 32'h1);
    for (int w = 0; w < 4; w++) begin
      for (int t = 0; t < 4; t++) begin
        v = 64'h0123_4567_89ab_cdef ^ {16{w[1:0], t[1:0]}};
        fwr(enc(w[1:0], t[1:0], 9'h1, 1'b0), v, 4'h0);
        fwr(enc(w[1:0], t[1:0], 9'h2, 1'b0), ~v, 4'h0);
        frd(enc(w[1:0], t[1:0], 9'h1, 1'b0), 4'h0);
        check("field", res, shape(w[1:0], v));
        frd(enc(w[1:0], t[1:0], 9'h2, 1'b0), 4'h0);
        check("field index", res, shape(w[1:0], ~v));
      end
    end
    v = 64'h0123_4567_89ab_cdef ^ {16{4'h4}};
    fwr(enc(2'b01, 2'b00, 9'h1, 1'b1), 64'hffff_ffff_1357_9bdf, 4'h0);
    frd(enc(2'b01, 2'b00, 9'h1, 1'b0), 4'h0);
    check("high write", res, {32'h1357_9bdf, v[31:0]});
    frd(enc(2'b01, 2'b00, 9'h1, 1'b1), 4'h0);
    check("high read", res, 64'h1357_9bdf);
    wr(vcf_pkg::OFF_CTRL, 32'h0);
    fwr(enc(2'b01, 2'b00, 9'h1, 1'b0), 64'hffff_ffff_2468_ace0, 4'h0);
    frd(enc(2'b01, 2'b00, 9'h1, 1'b0), 4'h0);
    check("low read", res, 64'h2468_ace0);
    frd(enc(2'b01, 2'b00, 9'h1, 1'b1), 4'h0);
    check("upper cleared", res, 64'h0);
    wr(vcf_pkg::OFF_ENC_HI, 32'h1);
    frd(enc(2'b00, 2'b00, 9'h1, 1'b0), 4'h0);
    wr(vcf_pkg::OFF_CTRL, 32'h1);
    v = res;
    frd(enc(2'b00, 2'b00, 9'h1, 1'b0), vcf_pkg::ERR_BAD_ENC);
    wr(vcf_pkg::OFF_ENC_HI, 32'h0);
    foreach (bad[i]) frd(bad[i], vcf_pkg::ERR_BAD_ENC);
    frd(enc(2'b00, 2'b00, 9'h4, 1'b0), vcf_pkg::ERR_NO_FIELD);
    check("result kept", res, v);
    op(vcf_pkg::OP_REPEAT_ENTRY, vcf_pkg::ERR_LAUNCH_STATE);
    op(vcf_pkg::OP_FIRST_ENTRY, 4'h0);
    flag(vcf_pkg::ST_LAUNCHED, 1'b1);
    op(vcf_pkg::OP_FIRST_ENTRY, vcf_pkg::ERR_LAUNCH_STATE);
    fwr(enc(2'b10, 2'b00, 9'h1, 1'b0), 64'h0, 4'h0);
    op(vcf_pkg::OP_REPEAT_ENTRY, 4'h0);
    wr(vcf_pkg::OFF_LINK_LO, 32'h0000_3000);
    wr(vcf_pkg::OFF_LINK_HI, 32'h0);
    op(vcf_pkg::OP_REPEAT_ENTRY, 4'h0);
    flag(vcf_pkg::ST_SHADOW_ACT, 1'b1);
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_3000);
    op(vcf_pkg::OP_CLEAR, 4'h0);
    flag(vcf_pkg::ST_SHADOW_ACT, 1'b0);
    flag(vcf_pkg::ST_CUR_VALID, 1'b1);
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_2000);
    op(vcf_pkg::OP_CLEAR, 4'h0);
    flag(vcf_pkg::ST_LAUNCHED, 1'b0);
    op(vcf_pkg::OP_FIRST_ENTRY, vcf_pkg::ERR_NO_CURRENT);
    op(vcf_pkg::OP_LOAD, 4'h0);
    op(vcf_pkg::OP_FIRST_ENTRY, 4'h0);
    wr(vcf_pkg::OFF_HDR, {1'b1, REV});
    wr(vcf_pkg::OFF_PTR_LO, 32'h0000_4000);
    op(vcf_pkg::OP_LOAD, 4'h0);
    flag(vcf_pkg::ST_CUR_SHADOW, 1'b1);
    op(vcf_pkg::OP_FIRST_ENTRY, vcf_pkg::ERR_SHADOW_ENTRY);
    op(4'h9, vcf_pkg::ERR_BAD_OP);
    op(vcf_pkg::OP_VIRT_DISABLE, 4'h0);
    flag(vcf_pkg::ST_ENABLED, 1'b0);
    op(vcf_pkg::OP_FIELD_READ, vcf_pkg::ERR_NOT_ENABLED);
    print_verdict();
  end
endmodule // vcf_field_access_tb
